// ---- design/lbc_pkg.sv ----
// Constants, types and field layout for the LCD booster clock control block
// Summary of operation
// - Two-bit source select: 0 fast oscillator, 1 slow oscillator, others reserved; reset 0.
// - Three-bit divider: fast 1/64 up to 1/4096, slow 1/8 up to 1/64; reset 0.
// - Enable bit 0 stops the booster clock; 1 forwards the divided clock.
// - Reference-level select: 0 lower level by default, 1 higher level.
// - One load-guard bit each for core and LCD regulators; 1 means protection mode.
package lbc_pkg;

  localparam int LBC_ADDR_W = 8;
  localparam int LBC_CNT_W  = 12;

  // Register word addresses
  localparam logic [7:0] LBC_ADDR_BCLK = 8'h00;
  localparam logic [7:0] LBC_ADDR_VREG = 8'h04;
  localparam logic [7:0] LBC_ADDR_CORE = 8'h08;
  localparam logic [7:0] LBC_ADDR_STAT = 8'h0C;

  // Field positions
  localparam int LBC_BCLK_ON_BIT    = 0;
  localparam int LBC_BCLK_SRC_LSB   = 2;
  localparam int LBC_BCLK_DIV_LSB   = 4;
  localparam int LBC_VREG_REF_BIT   = 0;
  localparam int LBC_VREG_GUARD_BIT = 4;
  localparam int LBC_CORE_GUARD_BIT = 0;
  localparam int LBC_STAT_RUN_BIT   = 0;
  localparam int LBC_STAT_BAD_BIT   = 1;
  localparam int LBC_STAT_LVL_BIT   = 2;

  // Reset values
  localparam logic [1:0] LBC_SRC_RST   = 2'h0;
  localparam logic [2:0] LBC_DIV_RST   = 3'h0;
  localparam logic       LBC_ON_RST    = 1'b0;
  localparam logic       LBC_REF_RST   = 1'b0;
  localparam logic       LBC_GUARD_RST = 1'b0;

  // Source codes and highest legal divider codes
  localparam logic [1:0] LBC_SRC_FAST     = 2'h0;
  localparam logic [1:0] LBC_SRC_SLOW     = 2'h1;
  localparam logic [2:0] LBC_DIV_FAST_MAX = 3'h6;
  localparam logic [2:0] LBC_DIV_SLOW_MAX = 3'h3;

  // Half periods in source edges for divider code 0 (1/64 and 1/8)
  localparam logic [11:0] LBC_FAST_HALF_BASE = 12'h020;
  localparam logic [11:0] LBC_SLOW_HALF_BASE = 12'h004;

  // AXI responses
  localparam logic [1:0] LBC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] LBC_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [2:0] div_sel;
    logic [1:0] src_sel;
    logic       on;
  } lbc_bclk_s;

  typedef struct packed {
    logic ref_sel;
    logic lcd_guard;
    logic core_guard;
  } lbc_reg_s;

  typedef enum logic [1:0] {
    LBC_WR_IDLE = 2'b01,
    LBC_WR_RESP = 2'b10
  } lbc_wr_e;

  typedef enum logic [1:0] {
    LBC_RD_IDLE = 2'b01,
    LBC_RD_RESP = 2'b10
  } lbc_rd_e;

endpackage

// ---- design/lbc_divider.sv ----
// Edge-counting divider for the booster clock
`timescale 1ns/1ps
module lbc_divider
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clear,
  input  wire logic        src_rise,
  input  wire logic [11:0] half_count,
  output logic             level
);

  logic [11:0] count;

  // Clear forces a fresh low phase so a new ratio starts clean
  always_ff @(posedge aclk)
  begin
    if (!aresetn || clear)
    begin
      count <= 12'h000;
      level <= 1'b0;
    end
    else if (src_rise)
    begin
      if (count == half_count - 12'h001)
      begin
        count <= 12'h000;
        level <= ~level;
      end
      else
      begin
        count <= count + 12'h001;
      end
    end
  end

endmodule

// ---- design/lbc_top.sv ----
// LCD booster clock control with AXI4-Lite register access
`timescale 1ns/1ps
module lbc_top
(
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic                        fast_osc_clock,
  input  wire logic                        slow_osc_clock,
  input  wire logic [lbc_pkg::LBC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                  s_axi_awprot,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [lbc_pkg::LBC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                  s_axi_arprot,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  output logic                             booster_clk_out,
  output logic                             lcd_reference_level_sel,
  output logic                             lcd_reg_load_guard,
  output logic                             core_reg_load_guard
);

  lbc_pkg::lbc_bclk_s           bclk;
  lbc_pkg::lbc_reg_s            regs;
  lbc_pkg::lbc_wr_e             wr_state;
  lbc_pkg::lbc_rd_e             rd_state;
  logic [lbc_pkg::LBC_ADDR_W-1:0] aw_addr;
  logic [31:0]                  w_data;
  logic                         w_lane0;
  logic                         write_fire;
  logic                         restart_div;
  logic [1:0]                   osc_sync1;
  logic [1:0]                   osc_sync2;
  logic [1:0]                   osc_prev;
  logic [1:0]                   osc_rise;
  logic                         src_is_slow;
  logic                         code_ok;
  logic                         src_rise;
  logic [11:0]                  half_count;
  logic                         div_clear;
  logic                         div_level;
  lbc_pkg::lbc_bclk_s           next_bclk;
  logic [31:0]                  next_rdata;
  logic [1:0]                   next_rresp;

  // Oscillators are foreign to aclk; two stages before any logic looks at them.
  // Sampling at 25 MHz limits the fast source to well below 12.5 MHz.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      osc_sync1 <= 2'h0;
      osc_sync2 <= 2'h0;
      osc_prev  <= 2'h0;
    end
    else
    begin
      osc_sync1 <= {slow_osc_clock, fast_osc_clock};
      osc_sync2 <= osc_sync1;
      osc_prev  <= osc_sync2;
    end
  end

  assign osc_rise = osc_sync2 & ~osc_prev;

  // Source and ratio selection
  assign src_is_slow = (bclk.src_sel == lbc_pkg::LBC_SRC_SLOW);
  assign src_rise    = src_is_slow ? osc_rise[1] : osc_rise[0];

  always_comb
  begin
    code_ok = 1'b0;
    if (bclk.src_sel == lbc_pkg::LBC_SRC_FAST)
    begin
      code_ok = (bclk.div_sel <= lbc_pkg::LBC_DIV_FAST_MAX);
    end
    else if (bclk.src_sel == lbc_pkg::LBC_SRC_SLOW)
    begin
      code_ok = (bclk.div_sel <= lbc_pkg::LBC_DIV_SLOW_MAX);
    end
  end

  // Each divider code doubles the ratio
  assign half_count = src_is_slow ? (lbc_pkg::LBC_SLOW_HALF_BASE << bclk.div_sel)
                                  : (lbc_pkg::LBC_FAST_HALF_BASE << bclk.div_sel);

  assign div_clear = ~bclk.on | ~code_ok | restart_div;

  lbc_divider u_divider
  (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .clear      (div_clear),
    .src_rise   (src_rise),
    .half_count (half_count),
    .level      (div_level)
  );

  // Gate is registered so the pin never glitches
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      booster_clk_out <= 1'b0;
    end
    else
    begin
      booster_clk_out <= bclk.on & code_ok & div_level;
    end
  end

  // Write address channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      aw_addr       <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      s_axi_awready <= 1'b0;
      aw_addr       <= s_axi_awaddr;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_wready <= 1'b1;
      w_data       <= 32'h00000000;
      w_lane0      <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      s_axi_wready <= 1'b0;
      w_data       <= s_axi_wdata;
      w_lane0      <= s_axi_wstrb[0];
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      s_axi_wready <= 1'b1;
    end
  end

  assign write_fire = (wr_state == lbc_pkg::LBC_WR_IDLE) && !s_axi_awready && !s_axi_wready;

  // Write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_state     <= lbc_pkg::LBC_WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= lbc_pkg::LBC_RESP_OKAY;
    end
    else
    begin
      case (wr_state)
        lbc_pkg::LBC_WR_IDLE:
        begin
          if (write_fire)
          begin
            wr_state     <= lbc_pkg::LBC_WR_RESP;
            s_axi_bvalid <= 1'b1;
            if (aw_addr == lbc_pkg::LBC_ADDR_BCLK || aw_addr == lbc_pkg::LBC_ADDR_VREG ||
                aw_addr == lbc_pkg::LBC_ADDR_CORE || aw_addr == lbc_pkg::LBC_ADDR_STAT)
            begin
              s_axi_bresp <= lbc_pkg::LBC_RESP_OKAY;
            end
            else
            begin
              s_axi_bresp <= lbc_pkg::LBC_RESP_SLVERR;
            end
          end
        end
        lbc_pkg::LBC_WR_RESP:
        begin
          if (s_axi_bready)
          begin
            wr_state     <= lbc_pkg::LBC_WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default:
        begin
          wr_state     <= lbc_pkg::LBC_WR_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // Booster control register; only byte lane 0 carries fields
  always_comb
  begin
    next_bclk         = bclk;
    next_bclk.on      = w_data[lbc_pkg::LBC_BCLK_ON_BIT];
    next_bclk.src_sel = w_data[lbc_pkg::LBC_BCLK_SRC_LSB +: 2];
    next_bclk.div_sel = w_data[lbc_pkg::LBC_BCLK_DIV_LSB +: 3];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bclk.on      <= lbc_pkg::LBC_ON_RST;
      bclk.src_sel <= lbc_pkg::LBC_SRC_RST;
      bclk.div_sel <= lbc_pkg::LBC_DIV_RST;
      restart_div  <= 1'b0;
    end
    else if (write_fire && w_lane0 && aw_addr == lbc_pkg::LBC_ADDR_BCLK)
    begin
      bclk        <= next_bclk;
      // Any ratio or source change restarts from zero, avoiding a runt phase
      restart_div <= (next_bclk.src_sel != bclk.src_sel) ||
                     (next_bclk.div_sel != bclk.div_sel);
    end
    else
    begin
      restart_div <= 1'b0;
    end
  end

  // Regulator control bits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      regs.ref_sel    <= lbc_pkg::LBC_REF_RST;
      regs.lcd_guard  <= lbc_pkg::LBC_GUARD_RST;
      regs.core_guard <= lbc_pkg::LBC_GUARD_RST;
    end
    else if (write_fire && w_lane0)
    begin
      if (aw_addr == lbc_pkg::LBC_ADDR_VREG)
      begin
        regs.ref_sel   <= w_data[lbc_pkg::LBC_VREG_REF_BIT];
        regs.lcd_guard <= w_data[lbc_pkg::LBC_VREG_GUARD_BIT];
      end
      else if (aw_addr == lbc_pkg::LBC_ADDR_CORE)
      begin
        regs.core_guard <= w_data[lbc_pkg::LBC_CORE_GUARD_BIT];
      end
    end
  end

  // Analog controls are static levels, one flop each
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lcd_reference_level_sel <= lbc_pkg::LBC_REF_RST;
      lcd_reg_load_guard      <= lbc_pkg::LBC_GUARD_RST;
      core_reg_load_guard     <= lbc_pkg::LBC_GUARD_RST;
    end
    else
    begin
      lcd_reference_level_sel <= regs.ref_sel;
      lcd_reg_load_guard      <= regs.lcd_guard;
      core_reg_load_guard     <= regs.core_guard;
    end
  end

  // Read decode; reserved bits read as zero
  always_comb
  begin
    next_rdata = 32'h00000000;
    next_rresp = lbc_pkg::LBC_RESP_OKAY;
    if (s_axi_araddr == lbc_pkg::LBC_ADDR_BCLK)
    begin
      next_rdata[lbc_pkg::LBC_BCLK_ON_BIT]       = bclk.on;
      next_rdata[lbc_pkg::LBC_BCLK_SRC_LSB +: 2] = bclk.src_sel;
      next_rdata[lbc_pkg::LBC_BCLK_DIV_LSB +: 3] = bclk.div_sel;
    end
    else if (s_axi_araddr == lbc_pkg::LBC_ADDR_VREG)
    begin
      next_rdata[lbc_pkg::LBC_VREG_REF_BIT]   = regs.ref_sel;
      next_rdata[lbc_pkg::LBC_VREG_GUARD_BIT] = regs.lcd_guard;
    end
    else if (s_axi_araddr == lbc_pkg::LBC_ADDR_CORE)
    begin
      next_rdata[lbc_pkg::LBC_CORE_GUARD_BIT] = regs.core_guard;
    end
    else if (s_axi_araddr == lbc_pkg::LBC_ADDR_STAT)
    begin
      next_rdata[lbc_pkg::LBC_STAT_RUN_BIT] = bclk.on & code_ok;
      next_rdata[lbc_pkg::LBC_STAT_BAD_BIT] = ~code_ok;
      next_rdata[lbc_pkg::LBC_STAT_LVL_BIT] = booster_clk_out;
    end
    else
    begin
      next_rresp = lbc_pkg::LBC_RESP_SLVERR;
    end
  end

  // Read channel: answer one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_state      <= lbc_pkg::LBC_RD_IDLE;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= lbc_pkg::LBC_RESP_OKAY;
    end
    else
    begin
      case (rd_state)
        lbc_pkg::LBC_RD_IDLE:
        begin
          if (s_axi_arvalid)
          begin
            rd_state      <= lbc_pkg::LBC_RD_RESP;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
          end
        end
        lbc_pkg::LBC_RD_RESP:
        begin
          if (s_axi_rready)
          begin
            rd_state      <= lbc_pkg::LBC_RD_IDLE;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
          end
        end
        default:
        begin
          rd_state      <= lbc_pkg::LBC_RD_IDLE;
          s_axi_arready <= 1'b1;
          s_axi_rvalid  <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ---- bench/lbc_monitor.sv ----
// Assertion checker on the booster clock control ports
`timescale 1ns/1ps
module lbc_monitor
(
  input wire logic                            aclk,
  input wire logic                            aresetn,
  input wire logic                            s_axi_awvalid,
  input wire logic                            s_axi_awready,
  input wire logic                            s_axi_wvalid,
  input wire logic                            s_axi_wready,
  input wire logic [1:0]                      s_axi_bresp,
  input wire logic                            s_axi_bvalid,
  input wire logic                            s_axi_bready,
  input wire logic [lbc_pkg::LBC_ADDR_W-1:0] s_axi_araddr,
  input wire logic                            s_axi_arvalid,
  input wire logic                            s_axi_arready,
  input wire logic [31:0]                     s_axi_rdata,
  input wire logic [1:0]                      s_axi_rresp,
  input wire logic                            s_axi_rvalid,
  input wire logic                            s_axi_rready,
  input wire logic                            booster_clk_out,
  input wire logic                            lcd_reference_level_sel,
  input wire logic                            lcd_reg_load_guard,
  input wire logic                            core_reg_load_guard
);
  logic [lbc_pkg::LBC_ADDR_W-1:0] ar_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Address of the read in flight, for response decoding
  always_ff @(posedge aclk)
    if (!aresetn)
      ar_q <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready)
      ar_q <= s_axi_araddr;

  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_reset_idle: assert property ($rose(aresetn) |-> !booster_clk_out && !lcd_reference_level_sel
    && !lcd_reg_load_guard && !core_reg_load_guard && s_axi_awready && s_axi_arready && !s_axi_bvalid)
    else $error("outputs not idle after reset");
  a_wr_latency: assert property (s_wr_both |-> !s_axi_bvalid ##2 s_axi_bvalid)
    else $error("write response late");
  a_rd_latency: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_resp_decode: assert property (s_axi_rvalid |-> s_axi_rresp == ((ar_q > 8'h0C || ar_q[1:0] != 2'h0) ? 2'h2 : 2'h0))
    else $error("read response code wrong");
  a_level_cause: assert property ($changed(lcd_reference_level_sel) || $changed(lcd_reg_load_guard)
    || $changed(core_reg_load_guard) |-> $past(s_axi_bvalid))
    else $error("regulator level moved without a write");
  a_clk_low_hold: assert property ($fell(booster_clk_out) |-> !booster_clk_out [*8])
    else $error("booster clock low phase too short");
  a_bad_code_low: assert property (s_axi_rvalid && ar_q == 8'h0C && s_axi_rdata[1] |-> !booster_clk_out)
    else $error("booster clock runs on reserved code");
endmodule

// ---- bench/lbc_top_tb.sv ----
// Self-checking bench for the booster clock control block
`timescale 1ns/1ps
module lbc_top_tb;
  logic        aclk          = 1'b0;
  logic        aresetn       = 1'b0;
  logic [3:0]  osc_cnt       = 4'h0;
  logic [7:0]  s_axi_awaddr  = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata   = 32'h0;
  logic [3:0]  s_axi_wstrb   = 4'hF;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_bready  = 1'b0;
  logic [7:0]  s_axi_araddr  = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready  = 1'b0;
  logic        s_axi_awready;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        booster_clk_out;
  logic        lcd_reference_level_sel;
  logic        lcd_reg_load_guard;
  logic        core_reg_load_guard;
  int          fail_count    = 0;
  int          compares      = 0;
  int          cycles        = 0;
  logic [1:0]  src_tab [8]   = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h0, 2'h1};
  logic [2:0]  div_tab [8]   = '{3'h0, 3'h2, 3'h0, 3'h3, 3'h0, 3'h0, 3'h7, 3'h4};

  always #20 aclk = ~aclk;

  // Oscillators tied to aclk so divided periods are exact: fast 8 cycles, slow 16
  always @(posedge aclk)
    osc_cnt <= osc_cnt + 4'h1;

  lbc_top lbc_top_inst
  (
    .aclk                    (aclk),
    .aresetn                 (aresetn),
    .fast_osc_clock          (osc_cnt[2]),
    .slow_osc_clock          (osc_cnt[3]),
    .s_axi_awaddr            (s_axi_awaddr),
    .s_axi_awprot            (3'h0),
    .s_axi_awvalid           (s_axi_awvalid),
    .s_axi_awready           (s_axi_awready),
    .s_axi_wdata             (s_axi_wdata),
    .s_axi_wstrb             (s_axi_wstrb),
    .s_axi_wvalid            (s_axi_wvalid),
    .s_axi_wready            (s_axi_wready),
    .s_axi_bresp             (s_axi_bresp),
    .s_axi_bvalid            (s_axi_bvalid),
    .s_axi_bready            (s_axi_bready),
    .s_axi_araddr            (s_axi_araddr),
    .s_axi_arprot            (3'h0),
    .s_axi_arvalid           (s_axi_arvalid),
    .s_axi_arready           (s_axi_arready),
    .s_axi_rdata             (s_axi_rdata),
    .s_axi_rresp             (s_axi_rresp),
    .s_axi_rvalid            (s_axi_rvalid),
    .s_axi_rready            (s_axi_rready),
    .booster_clk_out         (booster_clk_out),
    .lcd_reference_level_sel (lcd_reference_level_sel),
    .lcd_reg_load_guard      (lcd_reg_load_guard),
    .core_reg_load_guard     (core_reg_load_guard)
  );

  task automatic tally_and_finish;
    if (fail_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Ready is raised only after the answer shows, so the slave must hold it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, er);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk("rdata", d, ed);
    chk("rresp", r, er);
  endtask

  // Full output period in aclk cycles, measured between falling samples
  task automatic period(output int p);
    p = 0;
    while (booster_clk_out !== 1'b1)
      @(posedge aclk);
    while (booster_clk_out === 1'b1)
      @(posedge aclk);
    while (booster_clk_out !== 1'b1)
    begin
      @(posedge aclk);
      p++;
    end
    while (booster_clk_out === 1'b1)
    begin
      @(posedge aclk);
      p++;
    end
  endtask

  task automatic low_for(input int n, output logic hi);
    hi = 1'b0;
    repeat (n)
    begin
      @(posedge aclk);
      if (booster_clk_out !== 1'b0)
        hi = 1'b1;
    end
  endtask

  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end

  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    int          p;
    logic        hi;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 4; i++)
      rd_chk(8'(i * 4), 32'h0, 2'h0);
    wr(lbc_pkg::LBC_ADDR_VREG, 32'h11, 2'h0);
    wr(lbc_pkg::LBC_ADDR_CORE, 32'h1, 2'h0);
    repeat (2) @(posedge aclk);
    chk("levels", {lcd_reference_level_sel, lcd_reg_load_guard, core_reg_load_guard}, 3'h7);
    rd_chk(lbc_pkg::LBC_ADDR_VREG, 32'h11, 2'h0);
    wr(lbc_pkg::LBC_ADDR_VREG, 32'h10, 2'h0);
    wr(lbc_pkg::LBC_ADDR_CORE, 32'h0, 2'h0);
    repeat (2) @(posedge aclk);
    chk("levels", {lcd_reference_level_sel, lcd_reg_load_guard, core_reg_load_guard}, 3'h2);
    // Lane 0 off: fields must not move
    s_axi_wstrb <= 4'hE;
    wr(lbc_pkg::LBC_ADDR_VREG, 32'h1, 2'h0);
    s_axi_wstrb <= 4'hF;
    rd_chk(lbc_pkg::LBC_ADDR_VREG, 32'h10, 2'h0);
    wr(8'h10, 32'h1, 2'h2);
    rd_chk(8'h10, 32'h0, 2'h2);
    for (int i = 0; i < 8; i++)
    begin
      wr(lbc_pkg::LBC_ADDR_BCLK, {25'h0, div_tab[i], src_tab[i], 2'h1}, 2'h0);
      rd(lbc_pkg::LBC_ADDR_STAT, d, r);
      if (i < 4)
      begin
        chk("stat", d & 32'h3, 32'h1);
        period(p);
        chk("period", p, src_tab[i] == 2'h0 ? (64 << div_tab[i]) * 8 : (8 << div_tab[i]) * 16);
        // High phase outlasts one read, so the level bit is seen high
        while (booster_clk_out !== 1'b1)
          @(posedge aclk);
        rd(lbc_pkg::LBC_ADDR_STAT, d, r);
        chk("stat_high", d, 32'h5);
      end
      else
      begin
        chk("stat", d & 32'h3, 32'h2);
        low_for(600, hi);
        chk("held_low", hi, 1'b0);
      end
    end
    rd_chk(lbc_pkg::LBC_ADDR_BCLK, 32'h45, 2'h0);
    wr(lbc_pkg::LBC_ADDR_BCLK, 32'h0, 2'h0);
    low_for(600, hi);
    chk("held_low", hi, 1'b0);
    rd_chk(lbc_pkg::LBC_ADDR_STAT, 32'h0, 2'h0);
    tally_and_finish();
  end
endmodule

bind lbc_top lbc_monitor lbc_monitor_inst
(
  .aclk,
  .aresetn,
  .s_axi_awvalid,
  .s_axi_awready,
  .s_axi_wvalid,
  .s_axi_wready,
  .s_axi_bresp,
  .s_axi_bvalid,
  .s_axi_bready,
  .s_axi_araddr,
  .s_axi_arvalid,
  .s_axi_arready,
  .s_axi_rdata,
  .s_axi_rresp,
  .s_axi_rvalid,
  .s_axi_rready,
  .booster_clk_out,
  .lcd_reference_level_sel,
  .lcd_reg_load_guard,
  .core_reg_load_guard
);
